// >>> pkg/aam_pkg.sv
// Package for the alarm announcement manager: sizes, timing, codes, carrier types
package aam_pkg;

  // Number of condition channels handled
  localparam int unsigned AAM_NCH = 8;

  // Clock rate and one-second tick derivation
  localparam longint unsigned AAM_CLK_HZ     = 125000000;
  localparam int unsigned     AAM_TICK_CYCLES = int'(AAM_CLK_HZ);

  // Documented timing figures in seconds
  localparam int unsigned AAM_DELAY_MAX_S  = 30;
  localparam int unsigned AAM_IND_MAX_S    = 5;
  localparam int unsigned AAM_BACKUP_S     = 30;

  // Width of per-channel second counters
  localparam int unsigned AAM_SECW = 5;

  // Register bus geometry
  localparam int unsigned AAM_AW = 4;
  localparam int unsigned AAM_DW = 32;

  // Register offsets (byte addresses, word aligned)
  localparam logic [AAM_AW-1:0] AAM_REG_CTRL   = 4'h0;
  localparam logic [AAM_AW-1:0] AAM_REG_DELAY  = 4'h4;
  localparam logic [AAM_AW-1:0] AAM_REG_STATUS = 4'h8;
  localparam logic [AAM_AW-1:0] AAM_REG_ALARM  = 4'hC;

  // Control register field positions
  localparam int unsigned AAM_CTRL_WARN_AUD = 0;
  localparam int unsigned AAM_CTRL_LIMW     = 1;

  // Reset values
  localparam logic [AAM_SECW-1:0] AAM_DELAY_RST = 5'h00;
  localparam logic [AAM_DW-1:0]   AAM_ZERO32    = 32'h00000000;

  // Severity classes of a condition channel
  typedef enum logic [1:0] {
    AAM_SEV_IND   = 2'b00,
    AAM_SEV_WARN  = 2'b01,
    AAM_SEV_ALARM = 2'b10
  } aam_sev_type;

  // Per-channel announcement state
  typedef enum logic [1:0] {
    AAM_ST_IDLE  = 2'b00,
    AAM_ST_PEND  = 2'b01,
    AAM_ST_UNACK = 2'b10,
    AAM_ST_ACKED = 2'b11
  } aam_state_type;

  // Acknowledge and silence requests, one bit per channel per source
  typedef struct packed {
    logic [AAM_NCH-1:0] ack_local;
    logic [AAM_NCH-1:0] ack_wks;
    logic [AAM_NCH-1:0] ack_central;
    logic [AAM_NCH-1:0] sil_wks;
    logic [AAM_NCH-1:0] sil_local;
    logic [AAM_NCH-1:0] sil_central;
  } aam_req_type;

endpackage

// >>> rtl/aam_tick.sv
// One-second tick divider for the alarm announcement manager
`timescale 1ns/1ps
`default_nettype none

module aam_tick
  import aam_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = AAM_TICK_CYCLES
)(
  input  wire logic core_clk,
  input  wire logic nrst,
  output logic      tick
);

  // Divider counter
  logic [31:0] cnt_r;

  // Count cycles and pulse once per period
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b0;
    end else if (cnt_r >= 32'(TICK_CYCLES - 1)) begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h00000001;
      tick  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/aam_core.sv
// Alarm announcement manager: classification, delay, annunciation, escalation
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: Generation delay programmable, at most 30 s
// RULE2: Indication raised within 5 s while delayed
// RULE3: Alarm audible until acknowledged or silenced
// RULE4: Alarm visual until cleared and acknowledged
// RULE5: Unacknowledged alarms flash, acknowledged steady
// RULE6: Cleared unacknowledged alarm latches until acknowledged
// RULE7: One acknowledge clears repeated triggers
// RULE8: Warnings silent unless audible enable set
// RULE9: Warning visual until cleared and acknowledged
// RULE10: Unacknowledged warnings flash, acknowledged steady
// RULE11: Indications visual only, follow condition
// RULE12: Alarm acknowledge from panel or workstation
// RULE13: Function switched off auto acknowledges, cancels
// RULE14: Central alarm panel acknowledge accepted
// RULE15: Silencing from workstation; never for warnings (local and central panel silence also accepted)
// RULE16: Back-up alarm after 30 s unacknowledged
// RULE17: Back-up acknowledge only from bridge
// RULE18: Standby suppresses, bridge only, shown always
// RULE19: Standby blocks automatic control enables
// RULE20: Mismatched manual alarm limit raises warning
// RULE21: Invalid essential data alarm, else warning
// RULE22: No integrity check warns; alarm in control
// RULE23: Timers restart when cause clears or acknowledged
// RULE24: Timers run on one-second tick; reset clears
module aam_core
  import aam_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = AAM_TICK_CYCLES
)(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic [AAM_AW-1:0]  reg_addr,
  input  wire logic [AAM_DW-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [AAM_DW-1:0]  reg_rdata,
  input  wire logic [AAM_NCH-1:0] cond_invalid,
  input  wire logic [AAM_NCH-1:0] cond_essential,
  input  wire logic [AAM_NCH-1:0] cond_no_integrity,
  input  wire logic [AAM_NCH-1:0] cond_fault,
  input  wire logic [AAM_NCH-1:0] func_on,
  input  wire logic               active_control,
  input  wire aam_req_type        req,
  input  wire logic               backup_ack_bridge,
  input  wire logic               standby_req_bridge,
  input  wire logic               auto_ctrl_req,
  input  wire logic               limit_manual_entry,
  input  wire logic               limit_mismatch,
  output logic      [AAM_NCH-1:0] visual_on,
  output logic      [AAM_NCH-1:0] visual_flash,
  output logic      [AAM_NCH-1:0] indication_on,
  output logic                    audible,
  output logic                    backup_alarm,
  output logic                    standby_active,
  output logic                    auto_ctrl_enable,
  output logic                    limit_warning
);

  // Per-channel state and counters, then shared configuration, tick, blink and back-up state
  aam_state_type       st_r     [AAM_NCH];
  aam_sev_type         sev_r    [AAM_NCH];
  logic [AAM_SECW-1:0] dly_r    [AAM_NCH];
  logic [AAM_SECW-1:0] bkp_r    [AAM_NCH];
  logic [AAM_NCH-1:0]  sil_r;
  logic [AAM_NCH-1:0]  bkp_hit_r;
  logic [AAM_SECW-1:0] delay_cfg_r;
  logic [1:0]          ctrl_r;
  logic                blink_r;
  logic                tick;
  logic                backup_r;

  // Tick divider, shared by every timer
  aam_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick ( // RULE24
    .core_clk (core_clk),
    .nrst     (nrst),
    .tick     (tick)
  );

  // Clamp a programmed delay to the legal maximum
  function automatic logic [AAM_SECW-1:0] clamp_delay(input logic [AAM_DW-1:0] v);
    if (v > AAM_DW'(AAM_DELAY_MAX_S)) begin
      clamp_delay = AAM_SECW'(AAM_DELAY_MAX_S); // RULE1
    end else begin
      clamp_delay = v[AAM_SECW-1:0];
    end
  endfunction

  // Severity of one channel from its fault kind
  function automatic aam_sev_type classify(input logic ess, input logic noint,
                                           input logic actc);
    if (noint) begin
      classify = actc ? AAM_SEV_ALARM : AAM_SEV_WARN; // RULE22
    end else begin
      classify = ess ? AAM_SEV_ALARM : AAM_SEV_WARN; // RULE21
    end
  endfunction

  // Combined requests
  logic [AAM_NCH-1:0] cause;
  logic [AAM_NCH-1:0] ack_any;
  logic [AAM_NCH-1:0] sil_any;
  assign cause   = (cond_invalid | cond_no_integrity | cond_fault) & func_on;
  assign ack_any = req.ack_local | req.ack_wks | req.ack_central; // RULE12 RULE14
  assign sil_any = req.sil_wks | req.sil_local | req.sil_central; // RULE15

  // Blink phase toggles every second for the unacknowledged pattern
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blink_r <= 1'b0;
    end else if (tick) begin
      blink_r <= ~blink_r;
    end
  end

  // Per-channel announcement state machine
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < AAM_NCH; i++) begin
        st_r[i]  <= AAM_ST_IDLE; // RULE24
        sev_r[i] <= AAM_SEV_IND;
        dly_r[i] <= AAM_DELAY_RST;
        bkp_r[i] <= AAM_DELAY_RST;
      end
      sil_r     <= '0;
      bkp_hit_r <= '0;
    end else begin
      for (int i = 0; i < AAM_NCH; i++) begin
        // Function switched off cancels everything at once
        if (!func_on[i]) begin
          st_r[i]      <= AAM_ST_IDLE; // RULE13
          sil_r[i]     <= 1'b0;
          dly_r[i]     <= AAM_DELAY_RST;
          bkp_r[i]     <= AAM_DELAY_RST;
          bkp_hit_r[i] <= 1'b0;
        end else if (standby_active) begin
          // Standby holds channels quiet
          st_r[i]      <= AAM_ST_IDLE; // RULE18
          sil_r[i]     <= 1'b0;
          dly_r[i]     <= AAM_DELAY_RST;
          bkp_r[i]     <= AAM_DELAY_RST;
          bkp_hit_r[i] <= 1'b0;
        end else begin
          case (st_r[i])
            AAM_ST_IDLE: begin
              if (cause[i]) begin
                sev_r[i] <= classify(cond_essential[i], cond_no_integrity[i],
                                     active_control);
                dly_r[i] <= AAM_DELAY_RST;
                // Delay only applies to invalid or doubtful data
                if ((cond_invalid[i] | cond_no_integrity[i]) && delay_cfg_r != '0) begin
                  st_r[i] <= AAM_ST_PEND; // RULE1
                end else begin
                  st_r[i] <= AAM_ST_UNACK;
                end
              end
            end
            AAM_ST_PEND: begin
              if (!cause[i]) begin
                st_r[i]  <= AAM_ST_IDLE; // RULE23
                dly_r[i] <= AAM_DELAY_RST;
              end else if (tick) begin
                if (dly_r[i] + 1'b1 >= delay_cfg_r) begin
                  st_r[i] <= AAM_ST_UNACK;
                end
                dly_r[i] <= dly_r[i] + 1'b1;
              end
            end
            AAM_ST_UNACK: begin
              // One acknowledge clears however many retriggers occurred
              if (ack_any[i]) begin
                st_r[i]      <= cause[i] ? AAM_ST_ACKED : AAM_ST_IDLE; // RULE6 RULE7
                bkp_r[i]     <= AAM_DELAY_RST; // RULE23
                bkp_hit_r[i] <= 1'b0;
              end else if (tick && sev_r[i] == AAM_SEV_ALARM && !bkp_hit_r[i]) begin
                if (bkp_r[i] + 1'b1 >= AAM_SECW'(AAM_BACKUP_S)) begin
                  bkp_hit_r[i] <= 1'b1; // RULE16
                end
                bkp_r[i] <= bkp_r[i] + 1'b1;
              end
              if (sil_any[i] && sev_r[i] == AAM_SEV_ALARM) begin
                sil_r[i] <= 1'b1; // RULE15
              end
            end
            AAM_ST_ACKED: begin
              sil_r[i] <= 1'b0;
              if (!cause[i]) begin
                st_r[i] <= AAM_ST_IDLE; // RULE4 RULE9
              end
            end
            default: begin
              st_r[i] <= AAM_ST_IDLE;
            end
          endcase
          if (st_r[i] == AAM_ST_IDLE) begin
            sil_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  // Back-up officer alarm, acknowledged from the bridge only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      backup_r <= 1'b0;
    end else if (|bkp_hit_r) begin
      backup_r <= 1'b1; // RULE16
    end else if (backup_ack_bridge) begin
      backup_r <= 1'b0; // RULE17
    end
  end

  // Standby toggles on bridge request only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      standby_active <= 1'b0;
    end else if (standby_req_bridge) begin
      standby_active <= ~standby_active; // RULE18
    end
  end

  // Annunciation outputs, all registered
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      visual_on     <= '0;
      visual_flash  <= '0;
      indication_on <= '0;
      audible       <= 1'b0;
      backup_alarm  <= 1'b0;
    end else begin
      for (int i = 0; i < AAM_NCH; i++) begin
        visual_on[i] <= (st_r[i] == AAM_ST_UNACK) || (st_r[i] == AAM_ST_ACKED); // RULE4 RULE9
        // Flashing marks unacknowledged, steady marks acknowledged
        visual_flash[i] <= (st_r[i] == AAM_ST_UNACK) & blink_r; // RULE5 RULE10
        // Indication follows the cause directly, also covering a delay
        indication_on[i] <= cause[i] & ~standby_active; // RULE2 RULE11
      end
      audible <= 1'b0;
      for (int i = 0; i < AAM_NCH; i++) begin
        if (st_r[i] == AAM_ST_UNACK && !sil_r[i] && !standby_active) begin
          if (sev_r[i] == AAM_SEV_ALARM) begin
            audible <= 1'b1; // RULE3
          end else if (sev_r[i] == AAM_SEV_WARN && ctrl_r[AAM_CTRL_WARN_AUD]) begin
            audible <= 1'b1; // RULE8
          end
        end
      end
      backup_alarm <= backup_r;
    end
  end

  // Automatic control gating and alarm limit consistency
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      auto_ctrl_enable <= 1'b0;
      limit_warning    <= 1'b0;
    end else begin
      auto_ctrl_enable <= auto_ctrl_req & ~standby_active; // RULE19
      if (limit_manual_entry) begin
        limit_warning <= limit_mismatch; // RULE20
      end else if (!limit_mismatch) begin
        limit_warning <= 1'b0;
      end
    end
  end

  // Register writes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r      <= 2'h0;
      delay_cfg_r <= AAM_DELAY_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        AAM_REG_CTRL:  ctrl_r      <= reg_wdata[1:0];
        AAM_REG_DELAY: delay_cfg_r <= clamp_delay(reg_wdata); // RULE1
        default:       ;
      endcase
    end
  end

  // Register reads, data valid the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= AAM_ZERO32;
    end else if (reg_rd) begin
      case (reg_addr)
        AAM_REG_CTRL:   reg_rdata <= {30'h0, ctrl_r};
        AAM_REG_DELAY:  reg_rdata <= {27'h0, delay_cfg_r};
        AAM_REG_STATUS: reg_rdata <= {28'h0, limit_warning, auto_ctrl_enable,
                                      backup_alarm, standby_active};
        AAM_REG_ALARM:  reg_rdata <= {16'h0, visual_flash, visual_on};
        default:        reg_rdata <= AAM_ZERO32;
      endcase
    end else begin
      reg_rdata <= AAM_ZERO32;
    end
  end

  // Back-up alarm must follow a raise with no acknowledge
  a_backup_raise: assert property (@(posedge core_clk) disable iff (!nrst) // RULE16
    $rose(|bkp_hit_r) |=> ##1 backup_alarm)
    else $error("backup alarm not raised");

  // Standby forbids automatic control
  a_standby_block: assert property (@(posedge core_clk) disable iff (!nrst) // RULE19
    standby_active |=> !auto_ctrl_enable)
    else $error("auto control enabled in standby");

  // Switched-off function leaves no visual
  a_func_off: assert property (@(posedge core_clk) disable iff (!nrst) // RULE13
    !func_on[0] ##1 !func_on[0] |=> !visual_on[0])
    else $error("visual kept after function off");

  // Programmed delay stays within limit
  a_delay_max: assert property (@(posedge core_clk) disable iff (!nrst) // RULE1
    delay_cfg_r <= AAM_SECW'(AAM_DELAY_MAX_S))
    else $error("delay above limit");

  // Acknowledged alarm does not flash
  a_ack_steady: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
    st_r[0] == AAM_ST_ACKED |=> !visual_flash[0])
    else $error("acknowledged alarm flashing");

  // Indication follows cause
  a_ind_follow: assert property (@(posedge core_clk) disable iff (!nrst) // RULE2
    (cause[0] && !standby_active) |=> indication_on[0])
    else $error("indication missing");

  // No sound in standby
  a_standby_quiet: assert property (@(posedge core_clk) disable iff (!nrst) // RULE18
    standby_active && $past(standby_active) |=> !audible)
    else $error("audible in standby");

  // Acknowledge leaves unacknowledged state
  a_ack_once: assert property (@(posedge core_clk) disable iff (!nrst) // RULE7
    (st_r[0] == AAM_ST_UNACK && ack_any[0] && func_on[0] && !standby_active)
    |=> st_r[0] != AAM_ST_UNACK)
    else $error("acknowledge ignored");

endmodule

`default_nettype wire

// >>> verification/aam_panel_model.sv
// Operator panel model: acknowledge, silence and bridge requests
`timescale 1ns/1ps
`default_nettype none

module aam_panel_model
  import aam_pkg::*;
(
  input  wire logic core_clk,
  output var aam_req_type req,
  output var logic        bkp_ack,
  output var logic        stby_req
);
  // Idle panels request nothing
  initial begin
    req = '0;
    bkp_ack = 1'b0;
    stby_req = 1'b0;
  end

  // One request cycle, released at the edge that takes it
  // Panels never hold a request, so a stuck ack cannot mask a retrigger
  task automatic send(input aam_req_type r, input logic b, input logic s);
    @(posedge core_clk);
    req <= r;
    bkp_ack <= b;
    stby_req <= s;
    @(posedge core_clk);
    req <= '0;
    bkp_ack <= 1'b0;
    stby_req <= 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> verification/alarm_announcement_manager_bench.sv
// Self-checking bench for the alarm announcement manager
`timescale 1ns/1ps
`default_nettype none

module alarm_announcement_manager_bench
  import aam_pkg::*;
;
  localparam int unsigned TICK = 4; // Short second for simulation
  logic               core_clk;
  logic               nrst;
  logic [AAM_AW-1:0]  reg_addr;
  logic [AAM_DW-1:0]  reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [AAM_DW-1:0]  reg_rdata;
  logic [AAM_NCH-1:0] cond_invalid;
  logic [AAM_NCH-1:0] cond_essential;
  logic [AAM_NCH-1:0] cond_no_integrity;
  logic [AAM_NCH-1:0] cond_fault;
  logic [AAM_NCH-1:0] func_on;
  logic               active_control;
  aam_req_type        req;
  logic               bkp_ack;
  logic               stby_req;
  logic               auto_ctrl_req;
  logic               limit_manual_entry;
  logic               limit_mismatch;
  logic [AAM_NCH-1:0] visual_on;
  logic [AAM_NCH-1:0] visual_flash;
  logic [AAM_NCH-1:0] indication_on;
  logic               audible;
  logic               backup_alarm;
  logic               standby_active;
  logic               auto_ctrl_enable;
  logic               limit_warning;
  int                 n_errors;
  int                 n_tests;
  int                 seed;
  int                 ch;
  logic [AAM_DW-1:0]  d;
  logic               seen;

  aam_core #(.TICK_CYCLES(TICK)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cond_invalid(cond_invalid), .cond_essential(cond_essential),
    .cond_no_integrity(cond_no_integrity), .cond_fault(cond_fault),
    .func_on(func_on), .active_control(active_control), .req(req),
    .backup_ack_bridge(bkp_ack), .standby_req_bridge(stby_req),
    .auto_ctrl_req(auto_ctrl_req), .limit_manual_entry(limit_manual_entry),
    .limit_mismatch(limit_mismatch), .visual_on(visual_on), .visual_flash(visual_flash),
    .indication_on(indication_on), .audible(audible), .backup_alarm(backup_alarm),
    .standby_active(standby_active), .auto_ctrl_enable(auto_ctrl_enable),
    .limit_warning(limit_warning)
  );

  // Far-side panels
  aam_panel_model i_panel (.core_clk(core_clk), .req(req), .bkp_ack(bkp_ack),
    .stby_req(stby_req));

  // Free-running core clock, 8 ns
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Expected delay after a write: clamped at the documented ceiling
  function automatic logic [AAM_DW-1:0] exp_delay(input int v);
    return (v > AAM_DELAY_MAX_S) ? AAM_DW'(AAM_DELAY_MAX_S) : AAM_DW'(v);
  endfunction

  // One request bit: 0..2 acknowledge local/wks/central, 3..5 silence wks/local/central
  function automatic aam_req_type mk(input int src, input int c);
    logic [6*AAM_NCH-1:0] v;
    v = '0;
    v[(5-src)*AAM_NCH+c] = 1'b1;
    return aam_req_type'(v);
  endfunction

  task automatic check(input logic ok, input string what);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Waits, then samples clear of the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic cause(input int c, input logic inv, input logic ess, input logic noi,
                       input logic ac);
    @(posedge core_clk);
    cond_invalid[c] <= inv;
    cond_essential[c] <= ess;
    cond_no_integrity[c] <= noi;
    active_control <= ac;
  endtask

  task automatic wr(input logic [AAM_AW-1:0] a, input logic [AAM_DW-1:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [AAM_AW-1:0] a, output logic [AAM_DW-1:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Watches the flash output of one channel over a few seconds
  task automatic flash_seen(input int c);
    seen = 1'b0;
    repeat (3*TICK) begin
      cyc(1);
      if (visual_flash[c] === 1'b1) seen = 1'b1;
    end
  endtask

  initial begin
    {nrst, reg_wr, reg_rd, active_control, auto_ctrl_req} = '0;
    {limit_manual_entry, limit_mismatch, reg_addr, reg_wdata} = '0;
    {cond_invalid, cond_essential, cond_no_integrity, cond_fault} = '0;
    func_on = '1;
    {n_errors, n_tests} = '0;
    seed = 32'h9337ce3a;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    cyc(2);
    check(visual_on === '0 && audible === 1'b0, "quiet after reset");
    rd(AAM_REG_DELAY, d);
    check(d === AAM_ZERO32, "delay reset value");
    wr(AAM_REG_DELAY, 32'h00000028);
    rd(AAM_REG_DELAY, d);
    check(d === exp_delay(40), "delay clamp");
    rd(4'h2, d);
    check(d === AAM_ZERO32, "unmapped read");
    wr(AAM_REG_DELAY, AAM_ZERO32);
    $display("register test done");
    // Alarm life cycle, one acknowledge source per pass
    for (int s = 0; s < 3; s++) begin
      ch = $unsigned($random(seed)) % AAM_NCH;
      cause(ch, 1'b1, 1'b1, 1'b0, 1'b0);
      cyc(3);
      check(visual_on[ch] === 1'b1 && audible === 1'b1, "alarm raise");
      flash_seen(ch);
      check(seen, "unacked alarm flash");
      cause(ch, 1'b0, 1'b0, 1'b0, 1'b0);
      cause(ch, 1'b1, 1'b1, 1'b0, 1'b0);
      cause(ch, 1'b0, 1'b0, 1'b0, 1'b0);
      cyc(3);
      check(visual_on[ch] === 1'b1 && audible === 1'b1, "latched alarm");
      i_panel.send(mk(s, ch), 1'b0, 1'b0);
      cyc(3);
      check(visual_on[ch] === 1'b0 && audible === 1'b0, "one ack clears");
      $display("alarm test %0d done", s);
    end
    // Silence, then acknowledge with the cause still present
    ch = $unsigned($random(seed)) % AAM_NCH;
    cause(ch, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(3);
    i_panel.send(mk(3, ch), 1'b0, 1'b0);
    cyc(3);
    check(audible === 1'b0 && visual_on[ch] === 1'b1, "silence keeps visual");
    i_panel.send(mk(1, ch), 1'b0, 1'b0);
    cyc(3);
    check(visual_on[ch] === 1'b1 && audible === 1'b0, "acked alarm visual");
    flash_seen(ch);
    check(!seen, "acked alarm steady");
    cause(ch, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(3);
    check(visual_on[ch] === 1'b0, "cleared after ack");
    $display("silence test done");
    // Warnings; third pass escalates under active control
    for (int k = 0; k < 3; k++) begin
      ch = $unsigned($random(seed)) % AAM_NCH;
      cause(ch, k == 0, 1'b0, k != 0, k == 2);
      cyc(3);
      check(visual_on[ch] === 1'b1 && audible === (k == 2), "warning class");
      flash_seen(ch);
      check(seen, "unacked warning flash");
      i_panel.send(mk(2, ch), 1'b0, 1'b0);
      flash_seen(ch);
      check(!seen && visual_on[ch] === 1'b1, "acked warning steady");
      cause(ch, 1'b0, 1'b0, 1'b0, 1'b0);
      cyc(3);
      check(visual_on[ch] === 1'b0, "warning cleared");
      $display("warning test %0d done", k);
    end
    // Delayed generation with early indication
    wr(AAM_REG_DELAY, 32'h00000005);
    ch = $unsigned($random(seed)) % AAM_NCH;
    cause(ch, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(3);
    check(indication_on[ch] === 1'b1 && visual_on[ch] === 1'b0, "early indication");
    cyc(8);
    cause(ch, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(3*TICK);
    check(indication_on[ch] === 1'b0 && visual_on[ch] === 1'b0, "short fault");
    cause(ch, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(8);
    check(visual_on[ch] === 1'b0, "delay restarted");
    cyc(20);
    check(visual_on[ch] === 1'b1, "delayed alarm");
    i_panel.send(mk(0, ch), 1'b0, 1'b0);
    cause(ch, 1'b0, 1'b0, 1'b0, 1'b0);
    // Plain fault on non-essential data: undelayed warning, audible when enabled
    wr(AAM_REG_CTRL, 32'h00000001);
    rd(AAM_REG_CTRL, d);
    check(d === 32'h00000001, "ctrl readback");
    @(posedge core_clk);
    cond_fault[ch] <= 1'b1;
    cyc(3);
    check(visual_on[ch] === 1'b1 && audible === 1'b1, "fault warning audible");
    rd(AAM_REG_ALARM, d);
    check(d[ch] === 1'b1, "alarm register visual");
    i_panel.send(mk(3, ch), 1'b0, 1'b0);
    cyc(3);
    check(audible === 1'b1, "warning not silenced");
    i_panel.send(mk(1, ch), 1'b0, 1'b0);
    @(posedge core_clk);
    cond_fault[ch] <= 1'b0;
    cyc(3);
    check(visual_on[ch] === 1'b0 && audible === 1'b0, "fault warning cleared");
    wr(AAM_REG_CTRL, AAM_ZERO32);
    wr(AAM_REG_DELAY, AAM_ZERO32);
    $display("delay test done");
    // Function switched off cancels the alarm
    // Corner case: channel 0 is the one the design assertions watch
    ch = 0;
    cause(ch, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(3);
    @(posedge core_clk);
    func_on[ch] <= 1'b0;
    cyc(3);
    check(visual_on[ch] === 1'b0 && audible === 1'b0, "auto cancel");
    cause(ch, 1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge core_clk);
    func_on[ch] <= 1'b1;
    // Back-up officer alarm after thirty seconds unacknowledged
    cause(ch, 1'b1, 1'b1, 1'b0, 1'b0);
    for (int n = 0; n <= 40*TICK; n++) begin
      cyc(1);
      if (backup_alarm === 1'b1) begin
        check(n >= 29*TICK && n <= 31*TICK+4, "back-up timing");
        break;
      end
      if (n == 40*TICK) begin
        n_errors++;
        $display("BAD %0t back-up alarm never raised", $time);
        print_verdict();
      end
    end
    i_panel.send(mk(1, ch), 1'b0, 1'b0);
    cyc(3);
    check(backup_alarm === 1'b1, "back-up needs bridge");
    i_panel.send('0, 1'b1, 1'b0);
    cyc(3);
    check(backup_alarm === 1'b0, "bridge ack");
    cause(ch, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("back-up test done");
    // Standby mode and automatic control
    auto_ctrl_req <= 1'b1;
    cyc(3);
    check(auto_ctrl_enable === 1'b1, "auto control allowed");
    i_panel.send('0, 1'b0, 1'b1);
    cause(ch, 1'b1, 1'b1, 1'b0, 1'b0);
    cyc(3);
    check(standby_active === 1'b1 && auto_ctrl_enable === 1'b0, "standby");
    check(audible === 1'b0, "standby silent");
    cause(ch, 1'b0, 1'b0, 1'b0, 1'b0);
    i_panel.send('0, 1'b0, 1'b1);
    cyc(3);
    check(standby_active === 1'b0 && auto_ctrl_enable === 1'b1, "standby left");
    // Manual limit differing from the others
    @(posedge core_clk);
    limit_mismatch <= 1'b1;
    limit_manual_entry <= 1'b1;
    @(posedge core_clk);
    limit_manual_entry <= 1'b0;
    cyc(3);
    rd(AAM_REG_STATUS, d);
    check(limit_warning === 1'b1 && d[3] === 1'b1, "limit warning");
    $display("standby and limit test done");
    print_verdict();
  end
endmodule

`default_nettype wire
